/* verilog/ssr_status_byte.sv */
// status byte, service request mask and operation condition register
// assumes the message layer drives poll/query pulses and summary inputs
// What this block does
// [R01] serial poll shows request flag in bit 6
// [R02] status query shows master summary in bit 6
// [R03] master summary clears when all enabled sources clear
// [R04] status query changes neither flag
// [R05] bit 5 follows enabled standard event summary
// [R06] bit 4 follows pending output data
// [R07] enabled set status bit requests service
// [R08] mask is 8 bits, one per status bit
// [R09] mask resets to zero
// [R10] bits 0-3 read zero, mask bits stored
// [R11] mask bit 6 ignored
// [R12] operation group summarizes into bit 7
// [R13] condition register 16 bits, unused bits zero
// [R14] condition bits track live states
// [R15] bit 4 is measuring
// [R16] bit 3 is list sweeping
// [R17] bit 0 is correction measuring
// [R18] reading condition does not clear it
// [R19] bit 7 follows enabled operation events
// [R20] serial poll clears only the request flag
// [R21] events latch on condition falling edge
// [R22] request flag held until serial poll
`timescale 1ns/10ps
`default_nettype none
module ssr_status_byte
  import ssr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire ssr_req_t req_i,
  input wire ssr_dev_state_t dev_state_i,
  input wire logic esr_summary_i,
  input wire logic output_pending_flag_i,
  input wire logic [15:0] oper_event_enable_i,
  input wire logic oper_event_clear_i,
  output logic [7:0] poll_status_byte_o,
  output logic poll_valid_o,
  output logic [7:0] query_status_byte_o,
  output logic query_valid_o,
  output logic [7:0] service_request_mask_o,
  output logic [15:0] operation_condition_o,
  output logic [15:0] operation_event_o,
  output logic srq_o,
  output logic master_summary_flag_o
);

  // ************************************************************
  // helpers
  // ************************************************************
  // composes a status byte with a chosen bit 6
  function automatic logic [7:0] sb_compose(input logic [7:0] sum,
                                            input logic bit6);
    logic [7:0] b;
    b = sum & SB_SUMMARY_MASK; // [R10]
    b[SB_REQUEST_BIT] = bit6;
    return b;
  endfunction : sb_compose

  // ************************************************************
  // service request mask
  // ************************************************************
  logic [7:0] service_request_mask;

  // all eight bits stored as written; bit 6 dropped downstream
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      service_request_mask <= MASK_RESET; // [R09]
    end else if (clk_en_i && req_i.mask_write) begin
      service_request_mask <= req_i.mask_data; // [R08] [R10]
    end
  end

  assign service_request_mask_o = service_request_mask;

  // ************************************************************
  // operation status group
  // ************************************************************
  logic [15:0] cond;
  logic [15:0] fall;
  logic [15:0] oper_event;

  ssr_op_cond u_op_cond (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .dev_state_i(dev_state_i),
    .cond_o(cond),
    .fall_o(fall)
  );

  // sticky events; a falling edge in the clear cycle is kept
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oper_event <= OC_ZERO;
    end else if (clk_en_i) begin
      if (oper_event_clear_i) begin
        oper_event <= fall & OC_VALID_MASK; // [R21]
      end else begin
        oper_event <= (oper_event | fall) & OC_VALID_MASK; // [R21]
      end
    end
  end

  assign operation_condition_o = cond; // [R18]
  assign operation_event_o = oper_event;

  // ************************************************************
  // status byte summary bits
  // ************************************************************
  logic [7:0] summary;

  // live levels, no poll term, so polling cannot clear them
  always_comb begin
    summary = SB_ZERO;
    summary[SB_OPER_BIT] = |(oper_event & oper_event_enable_i); // [R12] [R19]
    summary[SB_ESB_BIT] = esr_summary_i; // [R05]
    summary[SB_PENDING_BIT] = output_pending_flag_i; // [R06]
  end

  // ************************************************************
  // request and master summary
  // ************************************************************
  logic request_service_flag;
  logic master_summary_flag;

  ssr_srq_gen u_srq_gen (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .summary_i(summary),
    .mask_i(service_request_mask),
    .serial_poll_i(req_i.serial_poll),
    .req_flag_o(request_service_flag)
  );

  // level; falls only when every enabled summary source is zero
  assign master_summary_flag =
    |(summary & service_request_mask & SB_SUMMARY_MASK); // [R03]
  assign master_summary_flag_o = master_summary_flag;
  // line held while the request flag stands
  assign srq_o = request_service_flag; // [R07] [R22]

  // ************************************************************
  // read answers
  // ************************************************************
  // poll byte captures the flag before the poll clears it
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      poll_status_byte_o <= SB_ZERO;
    end else if (clk_en_i && req_i.serial_poll) begin
      poll_status_byte_o <=
        sb_compose(summary, request_service_flag); // [R01] [R20]
    end
  end

  // query has no side effect on either flag
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      query_status_byte_o <= SB_ZERO;
    end else if (clk_en_i && req_i.stb_query) begin
      query_status_byte_o <=
        sb_compose(summary, master_summary_flag); // [R02] [R04]
    end
  end

  // valid strobes, one cycle after the request
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      poll_valid_o <= 1'b0;
      query_valid_o <= 1'b0;
    end else if (clk_en_i) begin
      poll_valid_o <= req_i.serial_poll;
      query_valid_o <= req_i.stb_query;
    end
  end

endmodule : ssr_status_byte
`default_nettype wire

/* verilog/ssr_pkg.sv */
// status byte / service request package: bit positions, reset values, types
// assumes a single 100 MHz clock domain; no register bus, registers on ports
`default_nettype none
package ssr_pkg;

  // ************************************************************
  // status byte layout
  // ************************************************************
  localparam int unsigned SB_W = 8;
  localparam int unsigned SB_OPER_BIT = 7;
  localparam int unsigned SB_REQUEST_BIT = 6;
  localparam int unsigned SB_ESB_BIT = 5;
  localparam int unsigned SB_PENDING_BIT = 4;
  localparam logic [7:0] SB_SUMMARY_MASK = 8'hB0;  // bits 7,5,4 only
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] SB_ZERO = 8'h00;

  // ************************************************************
  // operation condition / event layout
  // ************************************************************
  localparam int unsigned OC_W = 16;
  localparam int unsigned OC_MEAS_BIT = 4;
  localparam int unsigned OC_SWEEP_BIT = 3;
  localparam int unsigned OC_CORR_BIT = 0;
  localparam logic [15:0] OC_VALID_MASK = 16'h0019;
  localparam logic [15:0] OC_ZERO = 16'h0000;

  // live device states feeding the condition register
  typedef struct packed {
    logic measuring;
    logic sweeping;
    logic corr_measuring;
  } ssr_dev_state_t;

  // requests from the message layer
  typedef struct packed {
    logic serial_poll;   // poll handshake, one-cycle pulse
    logic stb_query;     // status byte query, one-cycle pulse
    logic mask_write;    // load service request mask
    logic [7:0] mask_data;
  } ssr_req_t;

  typedef enum logic {SSR_IDLE, SSR_PENDING} ssr_srq_state_t;

endpackage : ssr_pkg
`default_nettype wire

/* verilog/ssr_op_cond.sv */
// operation condition register with negative-edge event detect
// assumes dev state inputs synchronous to ref_clk_i
`timescale 1ns/10ps
`default_nettype none
module ssr_op_cond
  import ssr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire ssr_dev_state_t dev_state_i,
  output logic [15:0] cond_o,
  output logic [15:0] fall_o
);

  // ************************************************************
  // condition register and falling edge
  // ************************************************************
  logic [15:0] next_cond;

  // only three live states exist, all other bits tied low
  always_comb begin
    next_cond = OC_ZERO;
    next_cond[OC_MEAS_BIT] = dev_state_i.measuring;     // [R15]
    next_cond[OC_SWEEP_BIT] = dev_state_i.sweeping;     // [R16]
    next_cond[OC_CORR_BIT] = dev_state_i.corr_measuring; // [R17]
  end

  // follows the states both ways; reads never touch it
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cond_o <= OC_ZERO;
    end else if (clk_en_i) begin
      cond_o <= next_cond & OC_VALID_MASK; // [R13] [R14] [R18]
    end
  end

  // one-to-zero transitions only
  assign fall_o = clk_en_i ? (cond_o & ~next_cond) : OC_ZERO; // [R21]

endmodule : ssr_op_cond
`default_nettype wire

/* verilog/ssr_srq_gen.sv */
// service request generator: sets the request flag on a new enabled cause
// assumes poll pulses come from the bus handshake of the same clock
`timescale 1ns/10ps
`default_nettype none
module ssr_srq_gen
  import ssr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [7:0] summary_i,
  input wire logic [7:0] mask_i,
  input wire logic serial_poll_i,
  output logic req_flag_o
);

  // ************************************************************
  // request flag
  // ************************************************************
  logic [7:0] enabled;
  logic [7:0] enabled_q;
  logic new_cause;
  ssr_srq_state_t state;

  // bit 6 of the mask is dropped here, bits 0-3 are zero in summary
  assign enabled = summary_i & mask_i & SB_SUMMARY_MASK; // [R07] [R10] [R11]
  assign new_cause = |(enabled & ~enabled_q);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enabled_q <= SB_ZERO;
    end else if (clk_en_i) begin
      enabled_q <= enabled;
    end
  end

  // a new cause in the poll cycle wins, so it is never lost
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= SSR_IDLE;
    end else if (clk_en_i) begin
      unique case (state)
        SSR_IDLE: begin
          if (new_cause) begin
            state <= SSR_PENDING; // [R22]
          end
        end
        SSR_PENDING: begin
          if (serial_poll_i && !new_cause) begin
            state <= SSR_IDLE; // [R20]
          end
        end
      endcase
    end
  end

  assign req_flag_o = (state == SSR_PENDING);

endmodule : ssr_srq_gen
`default_nettype wire

/* verification/ssr_status_byte_properties.sv */
// checker for the status byte block: bytes, flags, mask and events
// assumes bind onto ssr_status_byte, one clock domain
`timescale 1ns/10ps
`default_nettype none
module ssr_status_byte_properties
  import ssr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire ssr_req_t req_i,
  input wire ssr_dev_state_t dev_state_i,
  input wire logic esr_summary_i,
  input wire logic output_pending_flag_i,
  input wire logic [15:0] oper_event_enable_i,
  input wire logic [7:0] poll_status_byte_o,
  input wire logic poll_valid_o,
  input wire logic [7:0] query_status_byte_o,
  input wire logic query_valid_o,
  input wire logic [7:0] service_request_mask_o,
  input wire logic [15:0] operation_condition_o,
  input wire logic [15:0] operation_event_o,
  input wire logic srq_o,
  input wire logic master_summary_flag_o
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_poll; clk_en_i && req_i.serial_poll; endsequence
  sequence s_query; clk_en_i && req_i.stb_query; endsequence
  // summary sources as they stand; bit 6 left out, it cannot be masked
  logic [7:0] sum_w;
  assign sum_w = {|(operation_event_o & oper_event_enable_i), 1'b0,
    esr_summary_i, output_pending_flag_i, 4'h0};
  poll_bit6_a: assert property (s_poll |=> poll_valid_o &&
    poll_status_byte_o[6] == $past(srq_o)) else $error("poll bit 6");
  query_bit6_a: assert property (s_query |=> query_valid_o &&
    query_status_byte_o[6] == $past(master_summary_flag_o))
    else $error("query bit 6");
  mss_sum_a: assert property (master_summary_flag_o ==
    |(sum_w & service_request_mask_o)) else $error("master summary");
  srq_hold_a: assert property (srq_o &&
    !(clk_en_i && req_i.serial_poll) |=> srq_o)
    else $error("request dropped without poll");
  nibble_zero_a: assert property ((poll_status_byte_o[3:0] |
    query_status_byte_o[3:0]) == 4'h0) else $error("low bits set");
  mask_load_a: assert property (clk_en_i && req_i.mask_write |=>
    service_request_mask_o == $past(req_i.mask_data)) else $error("mask");
  cond_track_a: assert property (clk_en_i |=>
    operation_condition_o == {11'h000, $past(dev_state_i.measuring),
    $past(dev_state_i.sweeping), 2'h0, $past(dev_state_i.corr_measuring)})
    else $error("condition");
  event_fall_a: assert property ($fell(operation_condition_o[4]) |->
    ##[0:1] operation_event_o[4]) else $error("event not latched");
  srq_rise_a: assert property (clk_en_i &&
    service_request_mask_o[4] && $rose(output_pending_flag_i) |->
    ##[0:2] srq_o) else $error("no srq");
  // summary bits of the poll byte are live levels, never cleared by it
  poll_summary_a: assert property (s_poll |=>
    (poll_status_byte_o & SB_SUMMARY_MASK) == $past(sum_w))
    else $error("poll summary bits");
  cond_zero_a: assert property (
    (operation_condition_o & ~OC_VALID_MASK) == OC_ZERO)
    else $error("unused condition bits set");
endmodule : ssr_status_byte_properties
`default_nettype wire

/* verification/ssr_ctrl_model.sv */
// bus controller model: serial polls, status queries, mask loads
// assumes the bench calls its tasks; each request is one clock wide
`timescale 1ns/10ps
`default_nettype none
module ssr_ctrl_model
  import ssr_pkg::*;
(
  input wire logic ref_clk_i,
  output ssr_req_t req_o
);
  // ************************************************************
  // requests
  // ************************************************************
  initial req_o = '0;
  // released data is inverted so a stale value never looks valid
  task automatic pulse(input ssr_req_t r);
    @(posedge ref_clk_i);
    req_o <= r;
    @(posedge ref_clk_i);
    req_o <= {3'h0, ~r.mask_data};
  endtask : pulse
  // mask values span the full 0 to 255 range of the 8-bit field
  task automatic load_mask(input logic [7:0] m);
    pulse({3'h1, m});
  endtask : load_mask
endmodule : ssr_ctrl_model
`default_nettype wire

/* verification/tb_top.sv */
// bench for the status byte block: one task per scenario
// assumes the controller model drives requests; 100 MHz clock
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import ssr_pkg::*;
;
  logic ref_clk_i;
  logic rst_n_i;
  logic clk_en_i;
  ssr_req_t req;
  ssr_dev_state_t dev;
  logic esr;
  logic pend;
  logic [15:0] oen;
  logic oclr;
  logic [7:0] pb;
  logic pv;
  logic [7:0] qb;
  logic qv;
  logic [7:0] mask;
  logic [15:0] cond;
  logic [15:0] evt;
  logic srq;
  logic msf;
  int n_mismatch;
  int tests_run;
  // ************************************************************
  // harness
  // ************************************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  ssr_ctrl_model u_ssr_ctrl_model (.ref_clk_i(ref_clk_i), .req_o(req));
  ssr_status_byte u_ssr_status_byte (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .req_i(req),
    .dev_state_i(dev), .esr_summary_i(esr), .output_pending_flag_i(pend),
    .oper_event_enable_i(oen), .oper_event_clear_i(oclr),
    .poll_status_byte_o(pb), .poll_valid_o(pv), .query_status_byte_o(qb),
    .query_valid_o(qv), .service_request_mask_o(mask),
    .operation_condition_o(cond), .operation_event_o(evt), .srq_o(srq),
    .master_summary_flag_o(msf));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  // byte stands from the taking edge on, so sample just after it
  task automatic poll_chk(input logic [7:0] exp);
    u_ssr_ctrl_model.pulse({3'h4, 8'h00});
    #1;
    chk(pv, 1'b1);
    chk(pb, exp);
  endtask : poll_chk
  task automatic query_chk(input logic [7:0] exp);
    u_ssr_ctrl_model.pulse({3'h2, 8'h00});
    #1;
    chk(qv, 1'b1);
    chk(qb, exp);
  endtask : query_chk
  task automatic t_mask();
    u_ssr_ctrl_model.load_mask(8'hFF);
    #1;
    chk(mask, 8'hFF);
    u_ssr_ctrl_model.load_mask(8'h40);
    @(posedge ref_clk_i);
    pend <= 1'b1;
    tick(3);
    chk(srq, 1'b0);
    query_chk(8'h10);
    @(posedge ref_clk_i);
    pend <= 1'b0;
  endtask : t_mask
  task automatic t_mav();
    u_ssr_ctrl_model.load_mask(8'h10);
    @(posedge ref_clk_i);
    pend <= 1'b1;
    tick(2);
    chk(srq, 1'b1);
    chk(msf, 1'b1);
    query_chk(8'h50);
    chk(srq, 1'b1);
    chk(msf, 1'b1);
    poll_chk(8'h50);
    chk(srq, 1'b0);
    chk(msf, 1'b1);
    poll_chk(8'h10);
    @(posedge ref_clk_i);
    pend <= 1'b0;
    tick(2);
    chk(msf, 1'b0);
    query_chk(8'h00);
  endtask : t_mav
  task automatic t_esr();
    u_ssr_ctrl_model.load_mask(8'h20);
    @(posedge ref_clk_i);
    esr <= 1'b1;
    tick(2);
    poll_chk(8'h60);
    poll_chk(8'h20);
    @(posedge ref_clk_i);
    esr <= 1'b0;
    tick(2);
    poll_chk(8'h00);
  endtask : t_esr
  task automatic t_oper();
    @(posedge ref_clk_i);
    oen <= 16'h0019;
    dev <= 3'h7;
    tick(5);
    chk(cond, 16'h0019);
    chk(evt, 16'h0000);
    @(posedge ref_clk_i);
    dev <= 3'h3;
    tick(3);
    chk(cond, 16'h0009);
    chk(evt, 16'h0010);
    poll_chk(8'h80);
    @(posedge ref_clk_i);
    dev <= 3'h0;
    tick(3);
    chk(evt, 16'h0019);
    @(posedge ref_clk_i);
    oclr <= 1'b1;
    @(posedge ref_clk_i);
    oclr <= 1'b0;
    tick(2);
    poll_chk(8'h00);
  endtask : t_oper
  // mid-run reset drops a written mask and a pending request; a write
  // made while the enable is low must not land after the release
  task automatic t_reset();
    u_ssr_ctrl_model.load_mask(8'h10);
    @(posedge ref_clk_i);
    pend <= 1'b1;
    tick(2);
    chk(srq, 1'b1);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    tick(1);
    chk(mask, 8'h00);
    chk(srq, 1'b0);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    clk_en_i <= 1'b0;
    u_ssr_ctrl_model.load_mask(8'hFF);
    #1;
    chk(mask, 8'h00);
    @(posedge ref_clk_i);
    clk_en_i <= 1'b1;
    tick(2);
    chk(srq, 1'b0);
    chk(msf, 1'b0);
    @(posedge ref_clk_i);
    pend <= 1'b0;
  endtask : t_reset
  task automatic complete_run();
    $display("mismatches %0d compares %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    {rst_n_i, esr, pend, oclr, dev, oen} = '0;
    clk_en_i = 1'b1;
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    tick(1);
    chk(mask, 8'h00);
    chk(cond, 16'h0000);
    t_mask();
    t_mav();
    t_esr();
    t_oper();
    t_reset();
    complete_run();
  end
endmodule : tb_top
bind ssr_status_byte ssr_status_byte_properties u_ssr_status_byte_properties (
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .clk_en_i(clk_en_i),
  .req_i(req_i),
  .dev_state_i(dev_state_i),
  .esr_summary_i(esr_summary_i),
  .output_pending_flag_i(output_pending_flag_i),
  .oper_event_enable_i(oper_event_enable_i),
  .poll_status_byte_o(poll_status_byte_o),
  .poll_valid_o(poll_valid_o),
  .query_status_byte_o(query_status_byte_o),
  .query_valid_o(query_valid_o),
  .service_request_mask_o(service_request_mask_o),
  .operation_condition_o(operation_condition_o),
  .operation_event_o(operation_event_o),
  .srq_o(srq_o),
  .master_summary_flag_o(master_summary_flag_o)
);
`default_nettype wire
